// ===== rtl/pgc_pkg.sv
// Notes on behaviour
// - with the colour-invert bit clear (reset) the pattern colours pass unmodified; with it set they are inverted.
// - with the auto-scroll bit clear (reset) the generator keeps its current pattern indefinitely.
// - with auto-scroll set the generator moves to the next enabled pattern each time the frame-time count of frames has elapsed.
// - an 8-bit read-write indirect address, reset to zero, selects the indirect register that data accesses target.
// - a write of the indirect data register delivers the byte into the indirect register that the address selects.
// - a read of the indirect data register returns the contents of the indirect register that the address selects.
package pgc_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // printed offsets are not multiples of four: byte address is four times the index
    localparam logic [7:0] IDX_CONFIG     = 8'h65;
    localparam logic [7:0] IDX_IND_ADDR   = 8'h66;
    localparam logic [7:0] IDX_IND_DATA   = 8'h67;
    localparam logic [7:0] IDX_FRAME_TIME = 8'h68;
    localparam logic [7:0] IDX_ENABLES    = 8'h69;
    localparam logic [7:0] IDX_STATUS     = 8'h6A;

    localparam logic [ADDR_W-1:0] ADDR_CONFIG     = {2'h0, IDX_CONFIG, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_IND_ADDR   = {2'h0, IDX_IND_ADDR, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_IND_DATA   = {2'h0, IDX_IND_DATA, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_FRAME_TIME = {2'h0, IDX_FRAME_TIME, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_ENABLES    = {2'h0, IDX_ENABLES, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_STATUS     = {2'h0, IDX_STATUS, 2'h0};

    localparam int unsigned BIT_AUTO_SCROLL  = 0;
    localparam int unsigned BIT_COLOR_INVERT = 1;

    localparam logic [7:0] RST_BYTE       = 8'h00;
    localparam logic [7:0] RST_FRAME_TIME = 8'h01;
    localparam logic [7:0] RST_ENABLES    = 8'h01;
    localparam int unsigned IND_DEPTH     = 256;
    localparam int unsigned NUM_PATTERNS  = 8;
    localparam int unsigned PAT_W         = 3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } pgc_color_t;
endpackage

// ===== rtl/pgc_scroll.sv
`timescale 1ns/10ps
module pgc_scroll (
    input  wire logic                         ref_clk,
    input  wire logic                         sys_rst,
    input  wire logic                         auto_scroll,
    input  wire logic [7:0]                   frame_time,
    input  wire logic [7:0]                   pat_enables,
    input  wire logic                         frame_start,
    output logic      [pgc_pkg::PAT_W-1:0]    pattern_sel
);
    logic [7:0]                frame_cnt_reg;
    logic [pgc_pkg::PAT_W-1:0] next_pat;

    // next enabled pattern after the current one, wrapping; stays put when none other is enabled
    always_comb begin
        next_pat = pattern_sel;
        for (int i = pgc_pkg::NUM_PATTERNS - 1; i >= 1; i--) begin
            if (pat_enables[3'(pattern_sel + 3'(i))]) begin
                next_pat = 3'(pattern_sel + 3'(i));
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            frame_cnt_reg <= pgc_pkg::RST_BYTE;
            pattern_sel   <= '0;
        end else if (!auto_scroll) begin
            frame_cnt_reg <= pgc_pkg::RST_BYTE;
        end else if (frame_start) begin
            // a frame time of zero is treated as one frame
            if (8'(frame_cnt_reg + 8'h01) >= frame_time) begin
                frame_cnt_reg <= pgc_pkg::RST_BYTE;
                pattern_sel   <= next_pat;
            end else begin
                frame_cnt_reg <= 8'(frame_cnt_reg + 8'h01);
            end
        end
    end
endmodule // pgc_scroll

// ===== rtl/pgc_top.sv
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
module pgc_top (
    input  wire logic                          ref_clk,
    input  wire logic                          sys_rst,
    input  wire logic [pgc_pkg::ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [pgc_pkg::DATA_W-1:0]    s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [pgc_pkg::ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [pgc_pkg::DATA_W-1:0]         s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic                          frame_start,
    input  wire pgc_pkg::pgc_color_t           pattern_color_in,
    output pgc_pkg::pgc_color_t                pattern_color_out,
    output logic [pgc_pkg::PAT_W-1:0]          pattern_sel,
    output logic [7:0]                         ind_wr_addr,
    output logic [7:0]                         ind_wr_data,
    output logic                               ind_wr_pulse
);
    logic [7:0]                     config_reg;
    logic [7:0]                     ind_addr_reg;
    logic [7:0]                     frame_time_reg;
    logic [7:0]                     enables_reg;
    logic [7:0]                     ind_mem [pgc_pkg::IND_DEPTH];
    logic                           aw_held_reg;
    logic                           w_held_reg;
    logic [pgc_pkg::ADDR_W-1:0]     awaddr_reg;
    logic [7:0]                     wbyte_reg;
    logic                           wstrb0_reg;
    logic                           do_write;
    logic [pgc_pkg::DATA_W-1:0]     rdata_next;
    logic                           rhit_next;

    // write channel: address and data taken independently, one write in flight
    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            awaddr_reg    <= '0;
            wbyte_reg     <= pgc_pkg::RST_BYTE;
            wstrb0_reg    <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= pgc_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_reg && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_held_reg && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wbyte_reg  <= s_axi_wdata[7:0];
                wstrb0_reg <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (awaddr_reg)
                    pgc_pkg::ADDR_CONFIG, pgc_pkg::ADDR_IND_ADDR, pgc_pkg::ADDR_IND_DATA,
                    pgc_pkg::ADDR_FRAME_TIME, pgc_pkg::ADDR_ENABLES, pgc_pkg::ADDR_STATUS: begin
                        s_axi_bresp <= pgc_pkg::RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= pgc_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // control registers; only byte lane 0 carries data
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            config_reg     <= pgc_pkg::RST_BYTE;
            ind_addr_reg   <= pgc_pkg::RST_BYTE;
            frame_time_reg <= pgc_pkg::RST_FRAME_TIME;
            enables_reg    <= pgc_pkg::RST_ENABLES;
        end else if (do_write && wstrb0_reg) begin
            case (awaddr_reg)
                pgc_pkg::ADDR_CONFIG:     config_reg     <= {6'h00, wbyte_reg[1:0]};
                pgc_pkg::ADDR_IND_ADDR:   ind_addr_reg   <= wbyte_reg;
                pgc_pkg::ADDR_FRAME_TIME: frame_time_reg <= wbyte_reg;
                pgc_pkg::ADDR_ENABLES:    enables_reg    <= wbyte_reg;
                default:                  ind_addr_reg   <= ind_addr_reg;
            endcase
        end
    end

    // indirect space; no reset so it maps to plain memory, hence it powers up undefined
    always_ff @(posedge ref_clk) begin
        if (do_write && wstrb0_reg && awaddr_reg == pgc_pkg::ADDR_IND_DATA) begin
            ind_mem[ind_addr_reg] <= wbyte_reg;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ind_wr_pulse <= 1'b0;
            ind_wr_addr  <= pgc_pkg::RST_BYTE;
            ind_wr_data  <= pgc_pkg::RST_BYTE;
        end else begin
            ind_wr_pulse <= do_write && wstrb0_reg && awaddr_reg == pgc_pkg::ADDR_IND_DATA;
            if (do_write && wstrb0_reg && awaddr_reg == pgc_pkg::ADDR_IND_DATA) begin
                ind_wr_addr <= ind_addr_reg;
                ind_wr_data <= wbyte_reg;
            end
        end
    end

    // read decode
    always_comb begin
        rdata_next = '0;
        rhit_next  = 1'b1;
        case (s_axi_araddr)
            pgc_pkg::ADDR_CONFIG:     rdata_next[7:0] = config_reg;
            pgc_pkg::ADDR_IND_ADDR:   rdata_next[7:0] = ind_addr_reg;
            pgc_pkg::ADDR_IND_DATA:   rdata_next[7:0] = ind_mem[ind_addr_reg];
            pgc_pkg::ADDR_FRAME_TIME: rdata_next[7:0] = frame_time_reg;
            pgc_pkg::ADDR_ENABLES:    rdata_next[7:0] = enables_reg;
            pgc_pkg::ADDR_STATUS:     rdata_next[pgc_pkg::PAT_W-1:0] = pattern_sel;
            default:                  rhit_next = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= pgc_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rdata_next;
                s_axi_rresp  <= rhit_next ? pgc_pkg::RESP_OKAY : pgc_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // colour output path
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pattern_color_out <= '0;
        end else if (config_reg[pgc_pkg::BIT_COLOR_INVERT]) begin
            pattern_color_out <= ~pattern_color_in;
        end else begin
            pattern_color_out <= pattern_color_in;
        end
    end

    pgc_scroll u_scroll (
        .ref_clk     (ref_clk),
        .sys_rst     (sys_rst),
        .auto_scroll (config_reg[pgc_pkg::BIT_AUTO_SCROLL]),
        .frame_time  (frame_time_reg),
        .pat_enables (enables_reg),
        .frame_start (frame_start),
        .pattern_sel (pattern_sel)
    );
endmodule // pgc_top

// ===== tb/pgc_properties.sv
`timescale 1ns/10ps
module pgc_props (
    input wire logic                ref_clk,
    input wire logic                sys_rst,
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic                s_axi_rvalid,
    input wire logic                s_axi_rready,
    input wire logic [31:0]         s_axi_rdata,
    input wire logic                s_axi_bvalid,
    input wire logic                s_axi_bready,
    input wire logic                frame_start,
    input wire pgc_pkg::pgc_color_t pattern_color_in,
    input wire pgc_pkg::pgc_color_t pattern_color_out,
    input wire logic [2:0]          pattern_sel,
    input wire logic [7:0]          ind_wr_addr,
    input wire logic [7:0]          ind_wr_data,
    input wire logic                ind_wr_pulse
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // first edge after reset still sees the reset value of the output, not the input, so it is skipped
    color_follow_a: assert property (!$past(sys_rst) |-> pattern_color_out == $past(pattern_color_in)
        || pattern_color_out == ~$past(pattern_color_in)) else $error("colour output not input or inverse");
    pulse_single_a: assert property (ind_wr_pulse |=> !ind_wr_pulse) else $error("write pulse too long");
    wr_hold_a: assert property (!ind_wr_pulse |-> $stable({ind_wr_addr, ind_wr_data}))
        else $error("indirect write bus moved without pulse");
    pulse_after_b_a: assert property (ind_wr_pulse |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("write pulse without write response");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("response dropped");
    sel_frame_a: assert property ($changed(pattern_sel) |-> $past(frame_start) || $past(frame_start, 2))
        else $error("pattern moved off frame");
endmodule // pgc_props
bind pgc_top pgc_props u_pgc_props (.ref_clk, .sys_rst, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .frame_start, .pattern_color_in,
    .pattern_color_out, .pattern_sel, .ind_wr_addr, .ind_wr_data, .ind_wr_pulse);

// ===== tb/pgc_tb.sv
`timescale 1ns/10ps
module tb;
    logic ref_clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, frame_start, ind_wr_pulse;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  s_axi_wstrb;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [7:0]  ind_wr_addr, ind_wr_data;
    logic [2:0]  pattern_sel;
    logic [7:0]  ia [3] = '{8'h00, 8'h7F, 8'hFF};
    int          n_fail = 0;
    int          n_checks = 0;
    pgc_pkg::pgc_color_t pattern_color_in, pattern_color_out;
    localparam logic [1:0]  OK = pgc_pkg::RESP_OKAY;
    localparam logic [11:0] CFG = pgc_pkg::ADDR_CONFIG;
    localparam logic [11:0] IA = pgc_pkg::ADDR_IND_ADDR;
    localparam logic [11:0] ID = pgc_pkg::ADDR_IND_DATA;
    pgc_top u_pgc_top (.ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .frame_start, .pattern_color_in, .pattern_color_out, .pattern_sel,
        .ind_wr_addr, .ind_wr_data, .ind_wr_pulse);
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        // ready rises only once the answer shows, so the slave must hold it a cycle
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, r);
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
        chk(s_axi_rresp, r);
        chk(s_axi_rdata, e);
        @(posedge ref_clk);
    endtask
    // the far end steps frames slowly so the registered pattern index has settled
    task automatic frames(input int n);
        repeat (n) begin
            frame_start <= 1'b1;
            @(posedge ref_clk);
            frame_start <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
    endtask
    task automatic reset_and_defaults;
        sys_rst <= 1'b1;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        rd(IA, 32'h0, OK);
        rd(CFG, 32'h0, OK);
        chk(pattern_sel, 32'h0);
        chk(pattern_color_out, pattern_color_in);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        {sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, frame_start} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        pattern_color_in = 24'h123456;
        reset_and_defaults();
        wr(CFG, 32'h2, OK);
        pattern_color_in <= 24'hFF00A5;
        repeat (2) @(posedge ref_clk);
        chk(pattern_color_out, 24'h00FF5A);
        foreach (ia[i]) begin
            wr(IA, {24'h0, ia[i]}, OK);
            wr(ID, {24'hFFFFFF, ia[i] ^ 8'h5A}, OK);
            chk({ind_wr_addr, ind_wr_data}, {16'h0, ia[i], ia[i] ^ 8'h5A});
            rd(IA, {24'h0, ia[i]}, OK);
        end
        foreach (ia[i]) begin
            wr(IA, {24'h0, ia[i]}, OK);
            rd(ID, {24'h0, ia[i] ^ 8'h5A}, OK);
            rd(ID, {24'h0, ia[i] ^ 8'h5A}, OK);
        end
        // lane 0 strobe low: answered but nothing written
        s_axi_wstrb <= 4'hE;
        wr(IA, 32'h33, OK);
        s_axi_wstrb <= 4'hF;
        rd(12'h000, 32'h0, pgc_pkg::RESP_SLVERR);
        wr(12'hFFC, 32'h5A, pgc_pkg::RESP_SLVERR);
        rd(IA, 32'hFF, OK);
        wr(pgc_pkg::ADDR_ENABLES, 32'h05, OK);
        wr(pgc_pkg::ADDR_FRAME_TIME, 32'h02, OK);
        wr(CFG, 32'h3, OK);
        frames(1);
        chk(pattern_sel, 32'h0);
        frames(1);
        chk(pattern_sel, 32'h2);
        rd(pgc_pkg::ADDR_STATUS, 32'h2, OK);
        wr(CFG, 32'h2, OK);
        frames(4);
        chk(pattern_sel, 32'h2);
        wr(CFG, 32'h3, OK);
        frames(2);
        chk(pattern_sel, 32'h0);
        reset_and_defaults();
        tally_and_finish();
    end
endmodule // tb
